// *** bench/pldm_board.sv ***
// board-side model driving the logic inputs, enable pin and sleep pin
`timescale 1ns/100ps
`default_nettype none
module pldm_board (
  input wire logic clk,
  output var logic sleep_request_pin,
  output var logic [pldm_pkg::N_IN-1:0] data_in,
  output var logic oe_n
);
  import pldm_pkg::*;
  // inputs stay quiet from time zero through the power-up clear
  initial begin
    sleep_request_pin = 1'b0;
    data_in = 8'h00;
    oe_n = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////
  // all changes land on the falling edge, clear of the sampling edge
  task automatic put(input logic [7:0] d, input logic o, input logic p);
    @(negedge clk);
    data_in = d;
    oe_n = o;
    sleep_request_pin = p;
  endtask
  // one full cycle of settled inputs before the request rises
  task automatic sleep_on();
    @(negedge clk);
    sleep_request_pin = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** bench/tb_top.sv ***
// self-checking bench for the sleep and power-up clear behaviour
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import pldm_pkg::*;
  logic clk, rst_n, sleep_option_en, sleep_request_pin, oe_n, asleep, powerup_busy;
  logic [N_IN-1:0] data_in;
  logic [MASK_W-1:0] tmask, cmask;
  logic [N_OUT-1:0] out_o, out_oe;
  int num_errors, n_compared, cycles;

  pldm_top #(.FAST_GRADE(1'b1)) u_pldm_top (.clk(clk), .rst_n(rst_n),
    .sleep_option_en(sleep_option_en), .sleep_request_pin(sleep_request_pin),
    .data_in(data_in), .oe_n(oe_n), .term_true_mask(tmask), .term_comp_mask(cmask),
    .out_o(out_o), .out_oe(out_oe), .asleep(asleep), .powerup_busy(powerup_busy));
  pldm_board u_pldm_board (.clk(clk), .sleep_request_pin(sleep_request_pin),
    .data_in(data_in), .oe_n(oe_n));

  // clock and hang guard
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      num_errors++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic results();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    int n;
    n = 0;
    repeat (2) @(negedge clk);
    chk(out_o, 8'hff);
    chk(out_oe, 8'h00);
    chk({7'h00, powerup_busy}, 8'h01);
    rst_n = 1'b1;
    while (powerup_busy !== 1'b0 && n < 80) begin
      @(negedge clk);
      chk(out_o, 8'hff);
      n++;
    end
    chk(n[7:0], 8'(2 + PWRUP_CYC));
  endtask
  task automatic t_load();
    u_pldm_board.put(8'ha5, 1'b0, 1'b0);
    @(negedge clk);
    chk(out_o, 8'h5a);
    chk(out_oe, 8'hff);
  endtask
  // inputs and enable wiggle while asleep; nothing may move
  task automatic t_sleep();
    u_pldm_board.put(8'h3c, 1'b0, 1'b0);
    u_pldm_board.sleep_on();
    @(negedge clk);
    chk(out_o, 8'hc3);
    chk({7'h00, asleep}, 8'h01);
    u_pldm_board.put(8'hff, 1'b1, 1'b1);
    repeat (4) @(negedge clk);
    chk(out_o, 8'hc3);
    chk(out_oe, 8'hff);
    u_pldm_board.put(8'hff, 1'b0, 1'b0);
    @(negedge clk);
    chk(out_o, 8'hc3);
    chk({7'h00, asleep}, 8'h00);
    // no edge in the recovery window is relied on
    repeat (2) begin
      @(negedge clk);
      chk(out_o, 8'hc3);
    end
    @(negedge clk);
    chk(out_o, 8'h00);
  endtask
  // a disabled output must stay disabled across the sleep
  task automatic t_hiz();
    u_pldm_board.put(8'h0f, 1'b1, 1'b0);
    @(negedge clk);
    chk(out_oe, 8'h00);
    u_pldm_board.sleep_on();
    u_pldm_board.put(8'h0f, 1'b0, 1'b1);
    repeat (3) @(negedge clk);
    chk(out_oe, 8'h00);
    chk(out_o, 8'hf0);
    u_pldm_board.put(8'h0f, 1'b0, 1'b0);
    repeat (4) @(negedge clk);
    chk(out_oe, 8'hff);
    chk(out_o, 8'hf0);
  endtask
  // option off: the dual pin only feeds term 1 of output 7
  task automatic t_opt_off();
    sleep_option_en = 1'b0;
    u_pldm_board.put(8'h00, 1'b0, 1'b1);
    @(negedge clk);
    chk(out_o, 8'h7f);
    chk({7'h00, asleep}, 8'h00);
    u_pldm_board.put(8'h00, 1'b0, 1'b0);
    @(negedge clk);
    chk(out_o, 8'hff);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // out k follows data_in[k]; impossible terms pad the rest, except term 1 of out 7, which reads the dual pin
  initial begin
    tmask = '0;
    cmask = '0;
    for (int k = 0; k < N_OUT; k++) begin
      tmask[k * N_TERMS * N_LIT + k] = 1'b1;
      for (int t = 1; t < N_TERMS; t++) begin
        tmask[(k * N_TERMS + t) * N_LIT] = 1'b1;
        cmask[(k * N_TERMS + t) * N_LIT] = 1'b1;
      end
    end
    tmask[(7 * N_TERMS + 1) * N_LIT] = 1'b0;
    cmask[(7 * N_TERMS + 1) * N_LIT] = 1'b0;
    tmask[(7 * N_TERMS + 1) * N_LIT + DUAL_LIT] = 1'b1;
    num_errors = 0;
    n_compared = 0;
    cycles = 0;
    sleep_option_en = 1'b1;
    // reset from time zero stands for the supply ramp from low
    rst_n = 1'b0;
    t_reset();
    t_load();
    t_sleep();
    t_hiz();
    t_opt_off();
    results();
  end
endmodule
`default_nettype wire

// *** rtl/pldm_array.sv ***
// sum-of-products array: eight terms per output, purely combinational
`timescale 1ns/100ps
`default_nettype none
module pldm_array (
  input wire logic [pldm_pkg::N_LIT-1:0] lit,
  input wire logic [pldm_pkg::MASK_W-1:0] true_mask,
  input wire logic [pldm_pkg::MASK_W-1:0] comp_mask,
  output logic [pldm_pkg::N_OUT-1:0] sum
);
  import pldm_pkg::*;

  // a term is true when every selected true literal is 1 and every
  // selected complement literal is 0; an unused term (no mask bits) reads 1
  function automatic logic term_hit(input logic [N_LIT-1:0] l,
                                    input logic [N_LIT-1:0] tm,
                                    input logic [N_LIT-1:0] cm);
    term_hit = &((l | ~tm) & (~l | ~cm));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  genvar o, t;
  generate
    for (o = 0; o < N_OUT; o++) begin : g_out
      logic [N_TERMS-1:0] hits;
      for (t = 0; t < N_TERMS; t++) begin : g_term
        localparam int B = (o * N_TERMS + t) * N_LIT;
        // each output gathers its own eight terms
        assign hits[t] = term_hit(lit, true_mask[B +: N_LIT], comp_mask[B +: N_LIT]);
      end
      assign sum[o] = |hits;
    end
  endgenerate
endmodule
`default_nettype wire

// *** rtl/pldm_pkg.sv ***
// shared constants and types for the power-managed logic array
package pldm_pkg;
  localparam int N_OUT = 8;            // registered outputs
  localparam int N_IN = 8;             // dedicated logic inputs
  localparam int N_TERMS = 8;          // product terms per output
  localparam int N_LIT = N_IN + 1 + N_OUT; // inputs, dual pin, feedback
  localparam int MASK_W = N_OUT * N_TERMS * N_LIT;
  localparam int DUAL_LIT = N_IN;      // literal slot of the dual-purpose pin

  // clock and timing figures, in ns
  localparam int CLK_NS = 20;
  localparam int PWRUP_CLEAR_MAX_NS = 1000; // powerup_clear_interval, longest
  localparam int WAKE_CLK_FAST_NS = 25;     // clock ignored after release, fast grade
  localparam int WAKE_CLK_SLOW_NS = 30;     // same, slow grade
  localparam int WAKE_OUT_FAST_NS = 30;     // outputs valid after release, fast grade
  localparam int WAKE_OUT_SLOW_NS = 35;     // same, slow grade

  // longest times round down, least times round up, never under one cycle
  localparam int PWRUP_CYC = (PWRUP_CLEAR_MAX_NS / CLK_NS < 1) ? 1
                             : PWRUP_CLEAR_MAX_NS / CLK_NS;
  localparam int WAKE_FAST_CYC = (WAKE_CLK_FAST_NS + CLK_NS - 1) / CLK_NS;
  localparam int WAKE_SLOW_CYC = (WAKE_CLK_SLOW_NS + CLK_NS - 1) / CLK_NS;
  localparam int OUT_FAST_CYC = (WAKE_OUT_FAST_NS / CLK_NS < 1) ? 1
                                : WAKE_OUT_FAST_NS / CLK_NS;
  localparam int OUT_SLOW_CYC = (WAKE_OUT_SLOW_NS / CLK_NS < 1) ? 1
                                : WAKE_OUT_SLOW_NS / CLK_NS;
  localparam int CNT_W = 6;

  // reset values
  localparam logic [N_OUT-1:0] REG_RST = 8'h00;
  localparam logic [N_OUT-1:0] PIN_RST = 8'hff;
  localparam logic [N_OUT-1:0] OE_RST = 8'h00;

  typedef enum logic [1:0] {
    PLDM_PWRUP,
    PLDM_RUN,
    PLDM_SLEEP,
    PLDM_WAKE
  } pldm_state_t;
endpackage

// *** rtl/pldm_top.sv ***
// registered logic array with pin-controlled sleep and power-up clear
//
// Contract
// - option set: dual pin requests sleep, active high
// - option clear: dual pin is ordinary array input
// - sleep holds every output data value
// - outputs disabled at sleep entry stay disabled
// - clock and inputs ignored while asleep
// - outputs valid within 30/35 ns of release
// - power-up clears all registers low
// - registered outputs therefore come up high
// - eight outputs, eight product terms each
`timescale 1ns/100ps
`default_nettype none
module pldm_top #(
  parameter bit FAST_GRADE = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic sleep_option_en,
  input wire logic sleep_request_pin,
  input wire logic [pldm_pkg::N_IN-1:0] data_in,
  input wire logic oe_n,
  input wire logic [pldm_pkg::MASK_W-1:0] term_true_mask,
  input wire logic [pldm_pkg::MASK_W-1:0] term_comp_mask,
  output logic [pldm_pkg::N_OUT-1:0] out_o,
  output logic [pldm_pkg::N_OUT-1:0] out_oe,
  output logic asleep,
  output logic powerup_busy
);
  import pldm_pkg::*;

  localparam logic [CNT_W-1:0] PWRUP_LAST = CNT_W'(PWRUP_CYC - 1);
  localparam logic [CNT_W-1:0] WAKE_LAST = FAST_GRADE ? CNT_W'(WAKE_FAST_CYC - 1)
                                                      : CNT_W'(WAKE_SLOW_CYC - 1);
  // outputs follow on the second edge after release, inside either grade's bound
  localparam int OUT_CYC = FAST_GRADE ? OUT_FAST_CYC : OUT_SLOW_CYC;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  logic rst_meta;
  logic rst_sync;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_meta <= 1'b0;
      rst_sync <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_sync <= rst_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dual-purpose pin: sleep request or plain literal
  logic sleep_req;
  logic [N_LIT-1:0] lit;
  logic [N_OUT-1:0] q;
  logic [N_OUT-1:0] sum;
  assign sleep_req = sleep_option_en & sleep_request_pin;
  // with the option on the pin never reaches the array
  assign lit = {q, sleep_request_pin & ~sleep_option_en, data_in};

  pldm_array u_array (
    .lit(lit),
    .true_mask(term_true_mask),
    .comp_mask(term_comp_mask),
    .sum(sum)
  );

  ////////////////////////////////////////////////////////////////////////////
  // sequencer and macrocell registers
  pldm_state_t st;
  pldm_state_t next_st;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic [N_OUT-1:0] next_q;

  always_comb begin
    next_st = st;
    next_cnt = cnt;
    next_q = q;
    case (st)
      PLDM_PWRUP: begin
        next_q = REG_RST;
        if (cnt == PWRUP_LAST) begin
          next_st = PLDM_RUN;
          next_cnt = '0;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      PLDM_RUN: begin
        // the edge that sees the request is already ignored
        if (sleep_req) begin
          next_st = PLDM_SLEEP;
        end else begin
          next_q = sum;
        end
      end
      PLDM_SLEEP: begin
        if (!sleep_req) begin
          next_st = PLDM_WAKE;
          next_cnt = '0;
        end
      end
      PLDM_WAKE: begin
        // edges in the recovery window would be unreliable, so drop them
        if (sleep_req) begin
          next_st = PLDM_SLEEP;
        end else if (cnt == WAKE_LAST) begin
          next_st = PLDM_RUN;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      default: begin
        next_st = PLDM_PWRUP;
        next_cnt = '0;
        next_q = REG_RST;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      st <= PLDM_PWRUP;
      cnt <= '0;
      q <= REG_RST;
    end else begin
      st <= next_st;
      cnt <= next_cnt;
      q <= next_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // output pins: data is the inverted register, enables from the oe pin
  logic [N_OUT-1:0] next_out_o;
  logic [N_OUT-1:0] next_out_oe;
  logic next_asleep;
  logic next_powerup_busy;
  logic freeze;
  // the release edge still holds out_o; the next edge, in the wake window, drives ~q
  assign freeze = sleep_req || (st == PLDM_SLEEP);

  always_comb begin
    next_out_o = out_o;
    next_out_oe = out_oe;
    next_asleep = (next_st == PLDM_SLEEP);
    next_powerup_busy = (next_st == PLDM_PWRUP);
    if (!freeze) begin
      next_out_o = ~next_q;
      next_out_oe = {N_OUT{~oe_n}};
    end
  end

  always_ff @(posedge clk or negedge rst_sync) begin
    if (!rst_sync) begin
      out_o <= PIN_RST;
      out_oe <= OE_RST;
      asleep <= 1'b0;
      powerup_busy <= 1'b1;
    end else begin
      out_o <= next_out_o;
      out_oe <= next_out_oe;
      asleep <= next_asleep;
      powerup_busy <= next_powerup_busy;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  AST_SLEEP_HOLDS_DATA: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_SLEEP && sleep_req) |=> $stable(out_o))
    else $error("output data moved during sleep");

  AST_SLEEP_HOLDS_HIZ: assert property (@(posedge clk) disable iff (!rst_sync)
    (asleep && sleep_req && out_oe == OE_RST) |=> (out_oe == OE_RST))
    else $error("disabled output enabled during sleep");

  AST_SLEEP_HOLDS_ENABLE: assert property (@(posedge clk) disable iff (!rst_sync)
    (asleep && sleep_req) |=> $stable(out_oe))
    else $error("output enable moved during sleep");

  AST_SLEEP_FREEZES_REGS: assert property (@(posedge clk) disable iff (!rst_sync)
    (sleep_req && st != PLDM_PWRUP) |=> $stable(q) && asleep)
    else $error("register changed while sleep requested");

  AST_WAKE_OUT_VALID: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_SLEEP && !sleep_req) |-> ##OUT_CYC (out_o == ~q && !asleep))
    else $error("outputs not valid after release");

  AST_WAKE_IGNORES_CLOCK: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_WAKE) |=> $stable(q))
    else $error("register loaded in wake window");

  AST_POWERUP_CLEAR: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_PWRUP) |-> (q == REG_RST && out_o == PIN_RST && powerup_busy))
    else $error("registers not clear during power-up");

  AST_POWERUP_ENDS: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_PWRUP && cnt == PWRUP_LAST) |=> (st == PLDM_RUN && !powerup_busy))
    else $error("power-up clear did not end on time");

  AST_DUAL_PIN_MODE: assert property (@(posedge clk) disable iff (!rst_sync)
    lit[DUAL_LIT] == (sleep_option_en ? 1'b0 : sleep_request_pin))
    else $error("dual pin routed wrongly");

  AST_PLAIN_INPUT: assert property (@(posedge clk) disable iff (!rst_sync)
    (!sleep_option_en && st == PLDM_RUN) |=> (q == $past(sum)))
    else $error("dual pin as input stalled the array");

  AST_OPTION_OFF_NO_SLEEP: assert property (@(posedge clk) disable iff (!rst_sync)
    (!sleep_option_en && st == PLDM_RUN) |=> !asleep)
    else $error("dual pin as input entered sleep");

  AST_RUN_LOAD: assert property (@(posedge clk) disable iff (!rst_sync)
    (st == PLDM_RUN && !sleep_req) |=> (q == $past(sum) && out_o == ~$past(sum)))
    else $error("array sum not registered");
endmodule
`default_nettype wire
